// ---- include/rcd_cfg.svh ----
// Overview of operation
// - source gives message as two 12-bit words
// - converter sends each 12-bit segment twice serially
// - first half loaded, duplicate compared bit-by-bit
// - second half loaded, duplicate compared bit-by-bit
// - mismatch clears register, replies transmission error
// - decode only after checks, MSB levels first
// - invalid level field stops, replies that level
// - first level picks group or guidance buffer
// - guidance selection forwards remaining bits out
// - thirty-two baseplates, four groups of eight
// - one addressed baseplate picks one of four modules
// - relay module sixteen relays, analog one converter
// - analog data applied only on exact duplicate match
// - analog mismatch keeps output, replies, resets receiver
// - relay module picks subgroup, buffers four bits
// - matched relay bits applied: 1 latch, 0 unlatch
// - relay mismatch not applied, replies, resets receiver
// - every command gets a reply, success included
// - reply is 12-bit code sent twice
// - converter compares reply halves, reports validity
// - source retries failed message, then isolates fault
`ifndef RCD_CFG_SVH
`define RCD_CFG_SVH

`define RCD_HALF_W 12
`define RCD_MSG_W 24
`define RCD_CMD_BITS 48
`define RCD_RPL_BITS 24
`define RCD_NUM_BP 32
`define RCD_NUM_MOD 128
`define RCD_RELAYS 16

// receive bit counter marks
`define RCD_CNT_SEG1 6'h0b
`define RCD_CNT_CHK1 6'h17
`define RCD_CNT_SEG2 6'h23
`define RCD_CNT_CHK2 6'h2f
`define RCD_CNT_RPL_LAST 5'h17

// message field positions
`define RCD_L1_LSB 21
`define RCD_BP_LSB 18
`define RCD_MOD_LSB 16
`define RCD_SUB_LSB 14
`define RCD_RDAT_LSB 10
`define RCD_RDUP_LSB 6
`define RCD_ADAT_LSB 8
`define RCD_ADUP_LSB 0
`define RCD_GNB_W 21
`define RCD_SEL_GNB 3'h4
`define RCD_SEL_GRP_MAX 3'h3

// reply codes
`define RCD_RPL_OK 12'h0f1
`define RCD_RPL_TX_ERR 12'h0e2
`define RCD_RPL_ADDR_L1 12'h0d3
`define RCD_RPL_ADDR_L2 12'h0c4
`define RCD_RPL_ADDR_L3 12'h0b5
`define RCD_RPL_CMP_ERR 12'h0a6
`define RCD_RPL_NONE 12'h000

// timing
`define RCD_CLK_NS 10
`define RCD_BIT_NS 80
`define RCD_BIT_DIV (`RCD_BIT_NS / `RCD_CLK_NS)
`define RCD_RPL_TMO_NS 20000
`define RCD_RPL_TMO (`RCD_RPL_TMO_NS / `RCD_CLK_NS)

`endif

// ---- include/rcd_pkg.sv ----
`include "rcd_cfg.svh"
package rcd_pkg;
  typedef logic [`RCD_HALF_W-1:0] rcd_half_type;
  typedef logic [`RCD_MSG_W-1:0] rcd_msg_type;
  typedef logic signed [7:0] rcd_dac_type;
  typedef logic [6:0] rcd_mod_idx_type;
  typedef logic [`RCD_RELAYS-1:0] rcd_bank_type;
  typedef enum logic [1:0] {RX_IDLE, RX_RECV, RX_DECODE, RX_REPLY} rcd_rx_state_type;
  typedef enum logic [1:0] {CV_IDLE, CV_SECOND, CV_SEND, CV_WAIT} rcd_cv_state_type;
endpackage

// ---- include/rcd_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface rcd_link_if;
  logic cmd_bit;
  logic cmd_valid;
  logic cmd_sof;
  logic rpl_bit;
  logic rpl_valid;
  modport conv (
    output cmd_bit,
    output cmd_valid,
    output cmd_sof,
    input rpl_bit,
    input rpl_valid
  );
  modport recv (
    input cmd_bit,
    input cmd_valid,
    input cmd_sof,
    output rpl_bit,
    output rpl_valid
  );
endinterface
`default_nettype wire

// ---- verilog/rcd_converter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rcd_cfg.svh"
module rcd_converter #(
  parameter int BIT_DIV = `RCD_BIT_DIV,
  parameter int RPL_TMO = `RCD_RPL_TMO
) (
  input wire logic clk_i,
  input wire logic rst_i,
  rcd_link_if.conv link,
  input wire logic cmd_valid_i,
  input wire rcd_pkg::rcd_half_type cmd_word_i,
  output logic cmd_ready_o,
  output logic rpl_valid_o,
  output logic rpl_ok_o,
  output rcd_pkg::rcd_half_type rpl_code_o
);
  import rcd_pkg::*;

  rcd_cv_state_type state_q;
  rcd_half_type w1_q;
  logic [`RCD_CMD_BITS-1:0] tx_q;
  logic [5:0] txcnt_q;
  logic [`RCD_RPL_BITS-1:0] rx_q;
  logic [4:0] rxcnt_q;
  logic [$clog2(RPL_TMO+1)-1:0] tmo_q;
  logic [$clog2(BIT_DIV+1)-1:0] div_q;
  logic tick;
  logic take;
  logic rx_last;
  logic tmo_hit;
  logic [`RCD_RPL_BITS-1:0] rx_nx;

  assign tick = (div_q == ($bits(div_q))'(BIT_DIV - 1));
  assign cmd_ready_o = (state_q == CV_IDLE) || (state_q == CV_SECOND);
  assign take = cmd_valid_i && cmd_ready_o;
  assign rx_nx = {rx_q[`RCD_RPL_BITS-2:0], link.rpl_bit};
  assign rx_last = (state_q == CV_WAIT) && link.rpl_valid && (rxcnt_q == `RCD_CNT_RPL_LAST);
  assign tmo_hit = (state_q == CV_WAIT) && (tmo_q == ($bits(tmo_q))'(RPL_TMO - 1));

  assign link.cmd_bit = tx_q[`RCD_CMD_BITS-1];
  assign link.cmd_valid = (state_q == CV_SEND) && tick;
  assign link.cmd_sof = (state_q == CV_SEND) && tick && (txcnt_q == 6'h00);

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != CV_SEND || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= CV_IDLE;
    end else begin
      unique case (state_q)
        CV_IDLE: if (take) state_q <= CV_SECOND;
        CV_SECOND: if (take) state_q <= CV_SEND;
        CV_SEND: if (tick && txcnt_q == `RCD_CNT_CHK2) state_q <= CV_WAIT;
        CV_WAIT: if (rx_last || tmo_hit) state_q <= CV_IDLE;
      endcase
    end
  end

  // two words in, each segment sent twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w1_q <= '0;
      tx_q <= '0;
      txcnt_q <= '0;
    end else if (take && state_q == CV_IDLE) begin
      w1_q <= cmd_word_i;
    end else if (take) begin
      tx_q <= {w1_q, w1_q, cmd_word_i, cmd_word_i};
      txcnt_q <= '0;
    end else if (state_q == CV_SEND && tick) begin
      tx_q <= {tx_q[`RCD_CMD_BITS-2:0], 1'b0};
      txcnt_q <= txcnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != CV_WAIT) begin
      rx_q <= '0;
      rxcnt_q <= '0;
      tmo_q <= '0;
    end else begin
      tmo_q <= tmo_q + 1'b1;
      if (link.rpl_valid) begin
        rx_q <= rx_nx;
        rxcnt_q <= rxcnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rpl_valid_o <= 1'b0;
      rpl_ok_o <= 1'b0;
      rpl_code_o <= '0;
    end else begin
      rpl_valid_o <= rx_last || tmo_hit;
      if (rx_last) begin
        rpl_ok_o <= rx_nx[`RCD_RPL_BITS-1:`RCD_HALF_W] == rx_nx[`RCD_HALF_W-1:0];
        rpl_code_o <= rx_nx[`RCD_RPL_BITS-1:`RCD_HALF_W];
      end else if (tmo_hit) begin
        rpl_ok_o <= 1'b0;
        rpl_code_o <= `RCD_RPL_NONE;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/rcd_receiver.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rcd_cfg.svh"
module rcd_receiver #(
  parameter int BIT_DIV = `RCD_BIT_DIV,
  parameter logic [`RCD_NUM_BP-1:0] BP_PRESENT = '1,
  parameter logic [`RCD_NUM_MOD-1:0] MOD_FITTED = '1,
  parameter logic [`RCD_NUM_MOD-1:0] MOD_IS_RELAY = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  rcd_link_if.recv link,
  output logic gnb_set_o,
  output logic [`RCD_GNB_W-1:0] gnb_data_o,
  output logic relay_set_o,
  output rcd_pkg::rcd_mod_idx_type relay_mod_o,
  output rcd_pkg::rcd_bank_type relay_bank_o,
  output logic dac_set_o,
  output rcd_pkg::rcd_mod_idx_type dac_mod_o,
  output rcd_pkg::rcd_dac_type dac_value_o,
  output logic rpl_done_o,
  output rcd_pkg::rcd_half_type rpl_code_o
);
  import rcd_pkg::*;

  rcd_rx_state_type state_q;
  logic [5:0] cnt_q;
  rcd_half_type sh_q;
  rcd_half_type seg_q;
  rcd_msg_type asm_q;
  logic [`RCD_RPL_BITS-1:0] tx_q;
  logic [4:0] txcnt_q;
  logic [$clog2(BIT_DIV+1)-1:0] div_q;
  rcd_bank_type relay_mem_q [`RCD_NUM_MOD];

  logic take;
  logic tick;
  rcd_half_type sh_nx;
  logic seg_end;
  logic chk;
  logic mis;
  logic load_rpl;
  logic rpl_end;
  rcd_half_type code_d;

  logic [2:0] l1;
  logic [4:0] bp_idx;
  rcd_mod_idx_type mod_idx;
  logic [1:0] sub_idx;
  logic [3:0] rdat;
  logic [3:0] rdup;
  logic [7:0] adat;
  logic [7:0] adup;
  rcd_half_type dec_code;
  logic do_gnb;
  logic do_relay;
  logic do_dac;
  rcd_bank_type bank_nx;

  // only a start flag opens a frame, so stray bits while idle are dropped
  assign take = link.cmd_valid &&
                ((state_q == RX_IDLE && link.cmd_sof) || state_q == RX_RECV);
  assign sh_nx = {sh_q[`RCD_HALF_W-2:0], link.cmd_bit};
  assign seg_end = take && (cnt_q == `RCD_CNT_SEG1 || cnt_q == `RCD_CNT_SEG2);
  assign chk = take && (cnt_q == `RCD_CNT_CHK1 || cnt_q == `RCD_CNT_CHK2);
  // duplicate segment checked bit by bit
  assign mis = chk && (sh_nx != seg_q);
  assign load_rpl = mis || state_q == RX_DECODE;
  assign tick = (div_q == ($bits(div_q))'(BIT_DIV - 1));
  assign rpl_end = state_q == RX_REPLY && tick && txcnt_q == `RCD_CNT_RPL_LAST;

  // twelve-bit code shifted out twice, msb first
  assign link.rpl_bit = tx_q[`RCD_RPL_BITS-1];
  assign link.rpl_valid = state_q == RX_REPLY && tick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= RX_IDLE;
    end else begin
      unique case (state_q)
        RX_IDLE: begin
          if (take) state_q <= RX_RECV;
        end
        RX_RECV: begin
          if (mis) begin
            state_q <= RX_REPLY;
          end else if (chk && cnt_q == `RCD_CNT_CHK2) begin
            state_q <= RX_DECODE;
          end
        end
        RX_DECODE: begin
          state_q <= RX_REPLY;
        end
        RX_REPLY: begin
          // back to idle once the reply is out
          if (rpl_end) state_q <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == RX_REPLY) begin
      cnt_q <= '0;
      sh_q <= '0;
    end else if (take) begin
      cnt_q <= cnt_q + 1'b1;
      sh_q <= sh_nx;
    end
  end

  // halves assembled, cleared on error or reply end
  always_ff @(posedge clk_i) begin
    if (rst_i || mis || rpl_end) begin
      seg_q <= '0;
      asm_q <= '0;
    end else if (seg_end) begin
      seg_q <= sh_nx;
      if (cnt_q == `RCD_CNT_SEG1) begin
        asm_q[`RCD_MSG_W-1:`RCD_HALF_W] <= sh_nx;
      end else begin
        asm_q[`RCD_HALF_W-1:0] <= sh_nx;
      end
    end
  end

  assign l1 = asm_q[`RCD_MSG_W-1:`RCD_L1_LSB];
  assign bp_idx = {l1[1:0], asm_q[`RCD_L1_LSB-1:`RCD_BP_LSB]};
  assign mod_idx = {bp_idx, asm_q[`RCD_BP_LSB-1:`RCD_MOD_LSB]};
  assign sub_idx = asm_q[`RCD_MOD_LSB-1:`RCD_SUB_LSB];
  assign rdat = asm_q[`RCD_SUB_LSB-1:`RCD_RDAT_LSB];
  assign rdup = asm_q[`RCD_RDAT_LSB-1:`RCD_RDUP_LSB];
  assign adat = asm_q[`RCD_MOD_LSB-1:`RCD_ADAT_LSB];
  assign adup = asm_q[`RCD_ADAT_LSB-1:`RCD_ADUP_LSB];

  // levels decoded top down, first bad level reported
  always_comb begin
    dec_code = `RCD_RPL_OK;
    do_gnb = 1'b0;
    do_relay = 1'b0;
    do_dac = 1'b0;
    // guidance buffer or one of four groups
    if (l1 == `RCD_SEL_GNB) begin
      do_gnb = 1'b1;
    end else if (l1 > `RCD_SEL_GRP_MAX) begin
      dec_code = `RCD_RPL_ADDR_L1;
    // one baseplate of eight, then one module
    end else if (!BP_PRESENT[bp_idx]) begin
      dec_code = `RCD_RPL_ADDR_L2;
    end else if (!MOD_FITTED[mod_idx]) begin
      dec_code = `RCD_RPL_ADDR_L3;
    end else if (MOD_IS_RELAY[mod_idx]) begin
      if (rdat == rdup) begin
        do_relay = 1'b1;
      end else begin
        dec_code = `RCD_RPL_CMP_ERR;
      end
    end else begin
      if (adat == adup) begin
        do_dac = 1'b1;
      end else begin
        dec_code = `RCD_RPL_CMP_ERR;
      end
    end
  end

  // ones latch, zeros unlatch the four relays
  always_comb begin
    bank_nx = relay_mem_q[mod_idx];
    bank_nx[{sub_idx, 2'b00} +: 4] = rdat;
  end

  // each relay module holds sixteen relay states
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `RCD_NUM_MOD; i++) begin
        relay_mem_q[i] <= '0;
      end
    end else if (state_q == RX_DECODE && do_relay) begin
      relay_mem_q[mod_idx] <= bank_nx;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_set_o <= 1'b0;
      relay_mod_o <= '0;
      relay_bank_o <= '0;
    end else begin
      relay_set_o <= state_q == RX_DECODE && do_relay;
      if (state_q == RX_DECODE && do_relay) begin
        relay_mod_o <= mod_idx;
        relay_bank_o <= bank_nx;
      end
    end
  end

  // converter level changes only on a match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_set_o <= 1'b0;
      dac_mod_o <= '0;
      dac_value_o <= '0;
    end else begin
      dac_set_o <= state_q == RX_DECODE && do_dac;
      if (state_q == RX_DECODE && do_dac) begin
        dac_mod_o <= mod_idx;
        dac_value_o <= adat;
      end
    end
  end

  // remaining bits handed to the guidance buffer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gnb_set_o <= 1'b0;
      gnb_data_o <= '0;
    end else begin
      gnb_set_o <= state_q == RX_DECODE && do_gnb;
      if (state_q == RX_DECODE && do_gnb) begin
        gnb_data_o <= asm_q[`RCD_GNB_W-1:0];
      end
    end
  end

  // every outcome yields a fixed code; all successes share one, both compare errors another
  assign code_d = mis ? `RCD_RPL_TX_ERR : dec_code;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= '0;
      txcnt_q <= '0;
      rpl_code_o <= '0;
    end else if (load_rpl) begin
      tx_q <= {code_d, code_d};
      txcnt_q <= '0;
      rpl_code_o <= code_d;
    end else if (state_q == RX_REPLY && tick) begin
      tx_q <= {tx_q[`RCD_RPL_BITS-2:0], 1'b0};
      txcnt_q <= txcnt_q + 1'b1;
    end
  end

  // bit pacing restarts with each reply so the first bit gets a full period
  always_ff @(posedge clk_i) begin
    if (rst_i || load_rpl || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // receiver ready again when the reply ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rpl_done_o <= 1'b0;
    end else begin
      rpl_done_o <= rpl_end;
    end
  end
endmodule
`default_nettype wire

// ---- tb/rcd_link_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module rcd_link_asserts #(
  parameter int BIT_DIV = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_bit,
  input wire logic cmd_valid,
  input wire logic cmd_sof,
  input wire logic rpl_bit,
  input wire logic rpl_valid
);
  logic [5:0] cnt_q;
  logic [4:0] rc_q;
  logic [11:0] cs_q;
  logic [11:0] rs_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // frame position lets the duplicate half be located bit by bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 6'h00;
    end else if (cmd_valid) begin
      cnt_q <= cmd_sof ? 6'h01 : cnt_q + 6'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_q <= 5'h00;
    end else if (rpl_valid) begin
      rc_q <= (rc_q == 5'h17) ? 5'h00 : rc_q + 5'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (cmd_valid) cs_q <= {cs_q[10:0], cmd_bit};
    if (rpl_valid) rs_q <= {rs_q[10:0], rpl_bit};
  end
  a_sof_with_bit: assert property (cmd_sof |-> cmd_valid)
    else $error("start mark without bit strobe");
  a_frame_start_mark: assert property (cmd_valid |-> (cmd_sof == (cnt_q == 6'h00 || cnt_q == 6'h30)))
    else $error("start mark not on first frame bit");
  a_cmd_pulse_once: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  a_cmd_bit_spacing: assert property (cmd_valid && (cmd_sof || cnt_q != 6'h2f) |-> ##BIT_DIV cmd_valid)
    else $error("command bit missing inside frame");
  a_cmd_dup_half: assert property (cmd_valid && !cmd_sof && (cnt_q inside {[12:23], [36:47]})
    |-> cmd_bit == cs_q[11])
    else $error("command half not repeated");
  a_rpl_pulse_once: assert property (rpl_valid |=> !rpl_valid)
    else $error("reply strobe longer than one cycle");
  a_rpl_bit_spacing: assert property (rpl_valid && rc_q != 5'h17 |-> ##BIT_DIV rpl_valid)
    else $error("reply bit missing");
  a_rpl_dup_half: assert property (rpl_valid && rc_q >= 5'h0c |-> rpl_bit == rs_q[11])
    else $error("reply half not repeated");
  a_rpl_after_check: assert property (rpl_valid |-> cnt_q >= 6'h18)
    else $error("reply before first duplicate check");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rcd_cfg.svh"
module testbench;
  import rcd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  rcd_half_type cmd_word_i = 12'h000;
  logic c3_valid = 1'b0;
  rcd_half_type c3_word = 12'h000;
  logic c3_rv, c3_ok;
  rcd_half_type c3_code;
  int n_c3, n_c3r;
  logic cmd_ready_o, rpl_valid_o, rpl_ok_o, gnb_set_o, relay_set_o, dac_set_o, e_rel, e_done;
  rcd_half_type rpl_code_o, e_code;
  logic [20:0] gnb_data_o;
  rcd_mod_idx_type relay_mod_o, dac_mod_o;
  rcd_bank_type relay_bank_o;
  rcd_dac_type dac_value_o;
  logic [47:0] fr;
  logic [23:0] rp;
  int bad_count = 0;
  int n_tests = 0;
  int n_rel, n_dac, n_gnb, n_erel, n_edone;
  rcd_link_if link();
  rcd_link_if link2();
  rcd_link_if link3();
  always #5 clk_i = ~clk_i;
  rcd_converter #(.BIT_DIV(2)) rcd_converter_inst (.clk_i(clk_i), .rst_i(rst_i),
    .link(link), .cmd_valid_i(cmd_valid_i), .cmd_word_i(cmd_word_i), .cmd_ready_o(cmd_ready_o),
    .rpl_valid_o(rpl_valid_o), .rpl_ok_o(rpl_ok_o), .rpl_code_o(rpl_code_o));
  // bp 31 absent, bp0 slot2 empty, bp0 slot1 analog
  rcd_receiver #(.BIT_DIV(2), .BP_PRESENT(32'h7fffffff), .MOD_FITTED(~128'h4),
    .MOD_IS_RELAY(~128'h2)) rcd_receiver_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .gnb_set_o(gnb_set_o), .gnb_data_o(gnb_data_o), .relay_set_o(relay_set_o),
    .relay_mod_o(relay_mod_o), .relay_bank_o(relay_bank_o), .dac_set_o(dac_set_o),
    .dac_mod_o(dac_mod_o), .dac_value_o(dac_value_o), .rpl_done_o(), .rpl_code_o());
  // second receiver faces a bench driver that corrupts frames on purpose
  rcd_receiver rcd_receiver_err_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link2),
    .gnb_set_o(), .gnb_data_o(), .relay_set_o(e_rel), .relay_mod_o(), .relay_bank_o(),
    .dac_set_o(), .dac_mod_o(), .dac_value_o(), .rpl_done_o(e_done), .rpl_code_o(e_code));
  // third converter hears a bench reply source that can garble or withhold replies
  rcd_converter rcd_converter_err_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link3),
    .cmd_valid_i(c3_valid), .cmd_word_i(c3_word), .cmd_ready_o(), .rpl_valid_o(c3_rv),
    .rpl_ok_o(c3_ok), .rpl_code_o(c3_code));
  rcd_link_asserts rcd_link_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_bit(link.cmd_bit), .cmd_valid(link.cmd_valid), .cmd_sof(link.cmd_sof),
    .rpl_bit(link.rpl_bit), .rpl_valid(link.rpl_valid));
  always @(posedge clk_i) begin
    if (link.cmd_valid) fr <= {fr[46:0], link.cmd_bit};
    if (link.rpl_valid) rp <= {rp[22:0], link.rpl_bit};
    if (relay_set_o === 1'b1) n_rel <= n_rel + 1;
    if (dac_set_o === 1'b1) n_dac <= n_dac + 1;
    if (gnb_set_o === 1'b1) n_gnb <= n_gnb + 1;
    if (e_rel === 1'b1) n_erel <= n_erel + 1;
    if (e_done === 1'b1) n_edone <= n_edone + 1;
    if (link3.cmd_valid === 1'b1) n_c3 <= n_c3 + 1;
    if (c3_rv === 1'b1) n_c3r <= n_c3r + 1;
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic c, input string s);
    n_tests++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, s);
    end
  endtask
  task automatic run(input logic [23:0] m, input rcd_half_type c);
    int i;
    n_rel = 0;
    n_dac = 0;
    n_gnb = 0;
    chk(cmd_ready_o === 1'b1, "not ready");
    cmd_word_i = m[23:12];
    cmd_valid_i = 1'b1;
    @(posedge clk_i);
    #1 cmd_word_i = m[11:0];
    @(posedge clk_i);
    #1 cmd_valid_i = 1'b0;
    chk(cmd_ready_o === 1'b0, "word taken while sending");
    for (i = 0; i < 600 && rpl_valid_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(i < 600, "no reply");
    if (i >= 600) stop_test();
    chk(fr === {m[23:12], m[23:12], m[11:0], m[11:0]}, "frame");
    chk(rp === {c, c}, "reply bits");
    chk(rpl_code_o === c && rpl_ok_o === 1'b1, "reply code");
  endtask
  task automatic frame2(input logic [47:0] f, input rcd_half_type c);
    int i;
    n_edone = 0;
    for (i = 47; i >= 0; i--) begin
      link2.cmd_bit = f[i];
      link2.cmd_valid = 1'b1;
      link2.cmd_sof = (i == 47);
      @(posedge clk_i);
      #1 link2.cmd_valid = 1'b0;
      link2.cmd_sof = 1'b0;
      link2.cmd_bit = ~f[i];
      @(posedge clk_i);
      #1;
    end
    for (i = 0; i < 300 && n_edone == 0; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(n_edone == 1 && e_code === c, "link2 reply");
    if (n_edone == 0) stop_test();
  endtask
  task automatic conv3(input rcd_half_type r1, input rcd_half_type r2, input logic talk,
    input logic ok, input rcd_half_type code);
    int i;
    n_c3 = 0;
    n_c3r = 0;
    c3_word = 12'h5a3;
    c3_valid = 1'b1;
    @(posedge clk_i);
    #1 c3_word = 12'h1c6;
    @(posedge clk_i);
    #1 c3_valid = 1'b0;
    for (i = 0; i < 600 && n_c3 < 48; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(n_c3 == 48, "converter frame length");
    if (n_c3 != 48) stop_test();
    for (i = 23; i >= 0 && talk; i--) begin
      link3.rpl_bit = (i > 11) ? r1[i - 12] : r2[i];
      link3.rpl_valid = 1'b1;
      @(posedge clk_i);
      #1 link3.rpl_valid = 1'b0;
      @(posedge clk_i);
      #1;
    end
    for (i = 0; i < 2500 && n_c3r == 0; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(n_c3r == 1 && c3_ok === ok && c3_code === code, "converter verdict");
    if (n_c3r == 0) stop_test();
  endtask
  // converter verdict on a garbled, a withheld and a clean reply
  task automatic t_retry;
    conv3(12'h0f1, 12'h0f0, 1'b1, 1'b0, 12'h0f1);
    conv3(12'h000, 12'h000, 1'b0, 1'b0, `RCD_RPL_NONE);
    conv3(`RCD_RPL_OK, `RCD_RPL_OK, 1'b1, 1'b1, `RCD_RPL_OK);
  endtask
  task automatic t_relay;
    run({3'h2, 3'h5, 2'h3, 2'h2, 4'ha, 4'ha, 6'h00}, `RCD_RPL_OK);
    chk(n_rel == 1 && relay_mod_o === 7'h57 && relay_bank_o === 16'h0a00, "latch");
    run({3'h2, 3'h5, 2'h3, 2'h0, 4'h3, 4'h3, 6'h00}, `RCD_RPL_OK);
    chk(relay_bank_o === 16'h0a03, "subgroup");
    run({3'h2, 3'h5, 2'h3, 2'h2, 4'h5, 4'h5, 6'h00}, `RCD_RPL_OK);
    chk(relay_bank_o === 16'h0503, "unlatch");
    run({3'h2, 3'h5, 2'h3, 2'h1, 4'hf, 4'he, 6'h00}, `RCD_RPL_CMP_ERR);
    chk(n_rel == 0 && relay_bank_o === 16'h0503, "relay held");
  endtask
  task automatic t_dac;
    run({3'h0, 3'h0, 2'h1, 8'h85, 8'h85}, `RCD_RPL_OK);
    chk(n_dac == 1 && n_rel == 0 && dac_mod_o === 7'h01 && dac_value_o === 8'h85, "dac");
    run({3'h0, 3'h0, 2'h1, 8'h12, 8'h13}, `RCD_RPL_CMP_ERR);
    chk(n_dac == 0 && dac_value_o === 8'h85, "dac held");
  endtask
  task automatic t_addr;
    logic [23:0] m [5] = '{24'ha00000, 24'hc00000, 24'he00000, 24'h7c0000, 24'h020000};
    rcd_half_type c [5] = '{`RCD_RPL_ADDR_L1, `RCD_RPL_ADDR_L1, `RCD_RPL_ADDR_L1,
      `RCD_RPL_ADDR_L2, `RCD_RPL_ADDR_L3};
    for (int k = 0; k < 5; k++) begin
      run(m[k], c[k]);
      chk(n_rel + n_dac + n_gnb == 0, "action on bad address");
    end
  endtask
  task automatic t_gnb;
    run({3'h4, 21'h1abcde}, `RCD_RPL_OK);
    chk(n_gnb == 1 && n_rel == 0 && gnb_data_o === 21'h1abcde, "guidance");
  endtask
  task automatic t_tx_err;
    logic [23:0] m = {3'h0, 3'h1, 2'h0, 2'h0, 4'h6, 4'h6, 6'h00};
    n_erel = 0;
    frame2({m[23:12], m[23:12] ^ 12'h001, m[11:0], m[11:0]}, `RCD_RPL_TX_ERR);
    frame2({m[23:12], m[23:12], m[11:0], m[11:0] ^ 12'h800}, `RCD_RPL_TX_ERR);
    chk(n_erel == 0, "action after bad frame");
    frame2({m[23:12], m[23:12], m[11:0], m[11:0]}, `RCD_RPL_OK);
    chk(n_erel == 1, "no action after clean frame");
  endtask
  initial begin
    link2.cmd_bit = 1'b0;
    link2.cmd_valid = 1'b0;
    link2.cmd_sof = 1'b0;
    link3.rpl_bit = 1'b0;
    link3.rpl_valid = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_relay();
    t_dac();
    t_addr();
    t_gnb();
    t_tx_err();
    t_retry();
    stop_test();
  end
endmodule
`default_nettype wire
